/* File: pbcr_basic_control.sv */
`timescale 1ns/1ns
`include "pbcr_regs.svh"

// Overview of operation
// - writing one to soft reset reloads all control fields to their reset values; the bit then reads zero.
// - loopback set blocks medium transmit and ignores medium receive data.
// - speed select one means 100BASE-TX, zero means 10BASE-T.
// - with auto-negotiation enabled, speed select has no effect on speed.
// - on reset, speed select loads highest speed allowed by technology straps.
// - speed select write takes effect only when technology straps allow it.
// - auto-negotiation enable accepts one only with ability pin high; resets to one then.
// - with auto-negotiation off, speed and duplex come from fields limited by straps.
// - ability pin rising without reset leaves enable zero until written one.
// - power-down field or power-down pin enters low-power state.
// - management transactions still answered while powered down.
// - isolate field or isolate pin floats all MII outputs.
// - management transactions still answered while isolated.
// - isolate field reset value follows the isolate-default strap.
// - writing one to restart starts negotiation again; the bit clears itself.
// - duplex field one means full duplex, zero means half duplex.
// - with auto-negotiation enabled, duplex field has no effect on duplex.
// - on reset, duplex loads highest duplex mode allowed by the straps.
// - duplex write takes effect only when technology straps allow the new mode.
// - collision test set asserts collision whenever transmit enable is high.
// - collision test suppressed while the coding sublayer is bypassed.
// - register reached over serial management pins, also at broadcast address.
module pbcr_basic_control (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [4:0] phy_addr,
  input  wire logic [2:0] technology_straps,
  input  wire logic       autoneg_ability_pin,
  input  wire logic       float_default_strap,
  input  wire logic       power_down_pin,
  input  wire logic       isolate_pin,
  input  wire logic       tx_en,
  input  wire logic       col_in,
  input  wire logic       pcs_bypass,
  input  wire logic       an_speed_100,
  input  wire logic       an_full_duplex,
  output logic            soft_reset_pulse,
  output logic            autoneg_restart_pulse,
  output logic            autoneg_active,
  output logic            op_speed_100,
  output logic            op_full_duplex,
  output logic            low_power,
  output logic            mii_float,
  output logic            medium_tx_enable,
  output logic            medium_rx_accept,
  output logic            loop_full_path,
  output logic            col_out
);

  // two-stage synchronisers for pins; third mdc stage for edge detect
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic        mdc3_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      mdc3_q  <= 1'b0;
    end else begin
      sync1_q <= {mdc, mdio_in, phy_addr, technology_straps, autoneg_ability_pin,
                  float_default_strap, power_down_pin, isolate_pin, tx_en, col_in};
      sync2_q <= sync1_q;
      mdc3_q  <= sync2_q[15];
    end
  end

  wire       mdc_s      = sync2_q[15];
  wire       mdio_s     = sync2_q[14];
  wire [4:0] addr_s     = sync2_q[13:9];
  wire [2:0] technology_straps_s     = sync2_q[8:6];
  wire       abil_pin_s = sync2_q[5];
  wire       iso_def_s  = sync2_q[4];
  wire       pd_pin_s   = sync2_q[3];
  wire       iso_pin_s  = sync2_q[2];
  wire       tx_en_s    = sync2_q[1];
  wire       col_in_s   = sync2_q[0];
  wire       mdc_rise   = mdc_s & ~mdc3_q;

  // abilities permitted by the technology straps
  logic [3:0] abil;
  always_comb begin
    unique case (technology_straps_s)
      `PBCR_TECHNOLOGY_STRAPS_10H:   abil = `PBCR_ABIL_10H;
      `PBCR_TECHNOLOGY_STRAPS_10HF:  abil = `PBCR_ABIL_10HF;
      `PBCR_TECHNOLOGY_STRAPS_100H:  abil = `PBCR_ABIL_100H;
      `PBCR_TECHNOLOGY_STRAPS_100HF: abil = `PBCR_ABIL_100HF;
      default:          abil = `PBCR_ABIL_ALL;
    endcase
  end

  wire ab_100 = abil[`PBCR_AB_100F] | abil[`PBCR_AB_100H];
  wire ab_10  = abil[`PBCR_AB_10F] | abil[`PBCR_AB_10H];
  wire def_speed  = ab_100;
  wire def_duplex = def_speed ? abil[`PBCR_AB_100F] : abil[`PBCR_AB_10F];

  // control fields
  logic loop_q;
  logic speed_q;
  logic anen_q;
  logic pd_q;
  logic iso_q;
  logic dup_q;
  logic collision_test_q;
  logic [1:0] init_q;
  logic soft_rst_q;
  logic restart_q;

  // management serial engine
  pbcr_pkg::pbcr_state_t state_q;
  logic [5:0]  cnt_q;
  logic [10:0] cmd_q;
  logic [15:0] sh_q;
  logic        drive_q;
  logic        is_read_q;
  logic        hit_q;

  // op and phy sit above the four register bits already shifted in
  wire [1:0] op_w    = cmd_q[10:9];
  wire [4:0] phy_w   = cmd_q[8:4];
  wire [4:0] reg_w   = {cmd_q[3:0], mdio_s};
  wire       addr_ok = (phy_w == addr_s) || (phy_w == `PBCR_BCAST_ADDR);
  wire       ctrl_ok = (reg_w == `PBCR_REG_CTRL);

  // self-clearing bits always read back zero
  wire [15:0] rd_val = {1'b0, loop_q, speed_q, anen_q, pd_q, iso_q, 1'b0,
                        dup_q, collision_test_q, `PBCR_RSVD_ZERO};

  wire        last_data = (state_q == pbcr_pkg::PBCR_DATA)
                          && (cnt_q[4:0] == `PBCR_DATA_BITS - 5'h01);
  wire        wr_fire   = mdc_rise && last_data && !is_read_q && hit_q;
  wire [15:0] wr_val    = {sh_q[14:0], mdio_s};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= pbcr_pkg::PBCR_PRE;
      cnt_q     <= 6'h00;
      cmd_q     <= 11'h000;
      sh_q      <= 16'h0000;
      drive_q   <= 1'b0;
      is_read_q <= 1'b0;
      hit_q     <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state_q)
        pbcr_pkg::PBCR_PRE: begin
          drive_q <= 1'b0;
          if (mdio_s) begin
            if (cnt_q != `PBCR_PRE_LEN) begin
              cnt_q <= cnt_q + 6'h01;
            end
          end else begin
            cnt_q   <= 6'h00;
            if (cnt_q == `PBCR_PRE_LEN) begin
              state_q <= pbcr_pkg::PBCR_START;
            end
          end
        end
        pbcr_pkg::PBCR_START: begin
          cnt_q   <= 6'h00;
          state_q <= mdio_s ? pbcr_pkg::PBCR_CMD : pbcr_pkg::PBCR_PRE;
        end
        pbcr_pkg::PBCR_CMD: begin
          cmd_q <= {cmd_q[9:0], mdio_s};
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q[3:0] == `PBCR_CMD_BITS - 4'h1) begin
            cnt_q     <= 6'h00;
            is_read_q <= (op_w == `PBCR_OP_READ);
            hit_q     <= addr_ok;
            // unsupported register addresses read as zero
            sh_q      <= ctrl_ok ? rd_val : 16'h0000;
            if (addr_ok && (op_w == `PBCR_OP_READ || op_w == `PBCR_OP_WRITE)) begin
              state_q <= pbcr_pkg::PBCR_TURN;
            end else begin
              state_q <= pbcr_pkg::PBCR_PRE;
            end
            hit_q <= addr_ok && ctrl_ok;
          end
        end
        pbcr_pkg::PBCR_TURN: begin
          cnt_q <= cnt_q + 6'h01;
          // drive the zero of the turnaround on reads
          if (cnt_q[1:0] == 2'h0) begin
            drive_q <= is_read_q;
          end
          if (cnt_q[1:0] == `PBCR_TA_BITS - 2'h1) begin
            cnt_q   <= 6'h00;
            state_q <= pbcr_pkg::PBCR_DATA;
          end
        end
        pbcr_pkg::PBCR_DATA: begin
          cnt_q <= cnt_q + 6'h01;
          if (is_read_q) begin
            sh_q <= {sh_q[14:0], 1'b0};
          end else begin
            sh_q <= wr_val;
          end
          if (last_data) begin
            cnt_q   <= 6'h00;
            drive_q <= 1'b0;
            state_q <= pbcr_pkg::PBCR_PRE;
          end
        end
        default: begin
          state_q <= pbcr_pkg::PBCR_PRE;
        end
      endcase
    end
  end

  wire in_data = (state_q == pbcr_pkg::PBCR_DATA);
  assign mdio_oe  = drive_q;
  assign mdio_out = drive_q & in_data & sh_q[15];

  // write acceptance against the straps
  wire new_speed = wr_val[`PBCR_BIT_SPEED];
  wire spd_ok    = new_speed ? ab_100 : ab_10;
  wire spd_next  = spd_ok ? new_speed : speed_q;
  wire new_dup   = wr_val[`PBCR_BIT_DUPLEX];
  wire full_ok   = spd_next ? abil[`PBCR_AB_100F] : abil[`PBCR_AB_10F];
  wire half_ok   = spd_next ? abil[`PBCR_AB_100H] : abil[`PBCR_AB_10H];
  wire dup_ok    = new_dup ? full_ok : half_ok;
  wire init_act  = (init_q != 2'h0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q     <= `PBCR_INIT_CYC;
      soft_rst_q <= 1'b0;
      restart_q  <= 1'b0;
      loop_q     <= 1'b0;
      speed_q    <= 1'b0;
      anen_q     <= 1'b0;
      pd_q       <= 1'b0;
      iso_q      <= 1'b0;
      dup_q      <= 1'b0;
      collision_test_q     <= 1'b0;
    end else begin
      soft_rst_q <= wr_fire & wr_val[`PBCR_BIT_RESET];
      restart_q  <= wr_fire & wr_val[`PBCR_BIT_RESTART];
      if (soft_rst_q) begin
        init_q <= `PBCR_INIT_CYC;
      end else if (init_act) begin
        init_q <= init_q - 2'h1;
      end
      if (soft_rst_q || init_act) begin
        // strap defaults reload until the synchronisers settle
        loop_q  <= 1'b0;
        pd_q    <= 1'b0;
        collision_test_q  <= 1'b0;
        speed_q <= def_speed;
        dup_q   <= def_duplex;
        anen_q  <= abil_pin_s;
        iso_q   <= iso_def_s;
      end else if (wr_fire) begin
        loop_q  <= wr_val[`PBCR_BIT_LOOP];
        pd_q    <= wr_val[`PBCR_BIT_POWER_DOWN];
        iso_q   <= wr_val[`PBCR_BIT_ISO];
        collision_test_q  <= wr_val[`PBCR_BIT_COLLISION_TEST];
        speed_q <= spd_next;
        anen_q  <= wr_val[`PBCR_BIT_ANEN] & abil_pin_s;
        if (dup_ok) begin
          dup_q <= new_dup;
        end
      end
    end
  end

  assign soft_reset_pulse      = soft_rst_q;
  assign autoneg_restart_pulse = restart_q;

  // operating mode and pin-combined controls
  wire an_on = anen_q & abil_pin_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      autoneg_active <= 1'b0;
      op_speed_100   <= 1'b0;
      op_full_duplex <= 1'b0;
      low_power      <= 1'b0;
      mii_float      <= 1'b0;
      col_out        <= 1'b0;
    end else begin
      autoneg_active <= an_on;
      op_speed_100   <= an_on ? an_speed_100 : speed_q;
      op_full_duplex <= an_on ? an_full_duplex : dup_q;
      low_power      <= pd_q | pd_pin_s;
      mii_float      <= iso_q | iso_pin_s;
      col_out        <= ~(iso_q | iso_pin_s)
                        & (col_in_s | (collision_test_q & tx_en_s & ~pcs_bypass));
    end
  end

  assign medium_tx_enable = ~loop_q & ~low_power;
  assign medium_rx_accept = ~loop_q;
  assign loop_full_path   = loop_q;

endmodule

/* File: pbcr_regs.svh */
`ifndef PBCR_REGS_SVH
`define PBCR_REGS_SVH

// management frame
`define PBCR_PRE_LEN      6'h20
`define PBCR_CMD_BITS     4'hC
`define PBCR_TA_BITS      2'h2
`define PBCR_DATA_BITS    5'h10
`define PBCR_OP_READ      2'h2
`define PBCR_OP_WRITE     2'h1
`define PBCR_BCAST_ADDR   5'h00
`define PBCR_REG_CTRL     5'h00

// control register fields
`define PBCR_BIT_RESET    15
`define PBCR_BIT_LOOP     14
`define PBCR_BIT_SPEED    13
`define PBCR_BIT_ANEN     12
`define PBCR_BIT_POWER_DOWN    11
`define PBCR_BIT_ISO      10
`define PBCR_BIT_RESTART  9
`define PBCR_BIT_DUPLEX   8
`define PBCR_BIT_COLLISION_TEST     7
`define PBCR_RSVD_ZERO    7'h00

// strap settling cycles after any reset
`define PBCR_INIT_CYC     2'h3

// ability vector bit positions
`define PBCR_AB_100F      3
`define PBCR_AB_100H      2
`define PBCR_AB_10F       1
`define PBCR_AB_10H       0

// technology strap codes to ability vectors
`define PBCR_TECHNOLOGY_STRAPS_10H     3'h0
`define PBCR_TECHNOLOGY_STRAPS_10HF    3'h1
`define PBCR_TECHNOLOGY_STRAPS_100H    3'h2
`define PBCR_TECHNOLOGY_STRAPS_100HF   3'h3
`define PBCR_ABIL_10H     4'h1
`define PBCR_ABIL_10HF    4'h3
`define PBCR_ABIL_100H    4'h4
`define PBCR_ABIL_100HF   4'hC
`define PBCR_ABIL_ALL     4'hF

`endif

/* File: pbcr_pkg.sv */
package pbcr_pkg;

  typedef enum logic [2:0] {
    PBCR_PRE,
    PBCR_START,
    PBCR_CMD,
    PBCR_TURN,
    PBCR_DATA
  } pbcr_state_t;

endpackage

/* File: pbcr_basic_control_properties.sv */
`timescale 1ns/1ns
module pbcr_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic autoneg_ability_pin,
  input wire logic power_down_pin,
  input wire logic isolate_pin,
  input wire logic tx_en,
  input wire logic col_in,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic soft_reset_pulse,
  input wire logic autoneg_restart_pulse,
  input wire logic autoneg_active,
  input wire logic op_speed_100,
  input wire logic op_full_duplex,
  input wire logic low_power,
  input wire logic mii_float,
  input wire logic medium_tx_enable,
  input wire logic medium_rx_accept,
  input wire logic loop_full_path,
  input wire logic col_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // negotiated result held steady while negotiation owns the mode
  sequence an_held;
    autoneg_active && $stable(an_speed_100) && $stable(an_full_duplex) ##1
      autoneg_active && $stable(an_speed_100) && $stable(an_full_duplex);
  endsequence
  rx_ignore_a: assert property (medium_rx_accept == !loop_full_path) else $error("rx accept wrong");
  tx_block_a: assert property (medium_tx_enable == !(loop_full_path || low_power)) else $error("tx gate wrong");
  soft_clear_a: assert property (soft_reset_pulse |=> !soft_reset_pulse ##[0:2] !loop_full_path) else $error("soft");
  restart_clear_a: assert property (autoneg_restart_pulse |=> !autoneg_restart_pulse) else $error("restart");
  an_gate_a: assert property (autoneg_active |-> $past(autoneg_ability_pin, 3)) else $error("an gate");
  pd_enter_a: assert property ($rose(power_down_pin) |-> ##3 low_power) else $error("power down");
  iso_enter_a: assert property ($rose(isolate_pin) |-> ##3 mii_float) else $error("isolate");
  col_cause_a: assert property (col_out |-> $past(col_in, 3) || $past(tx_en, 3)) else $error("col");
  an_mode_a: assert property (an_held |-> op_speed_100 == an_speed_100 && op_full_duplex == an_full_duplex)
    else $error("an mode");
endmodule

/* File: pbcr_mgmt_station.sv */
`timescale 1ns/1ns
module pbcr_mgmt_station (
  input  wire logic        ref_clk,
  input  wire logic        mdio,
  output logic             mdc,
  output logic             sta_out,
  output logic             sta_oe,
  output logic             rd_done,
  output logic [15:0]      rd_data
);
  initial begin
    mdc = 1'b0;
    sta_out = 1'b1;
    sta_oe = 1'b0;
    rd_done = 1'b0;
    rd_data = 16'h0000;
  end
  // one bit: data set at mdc fall, line sampled just before the rise
  task automatic bit_cyc(input logic b, input logic oe, output logic s);
    @(posedge ref_clk) #1;
    sta_out = b;
    sta_oe = oe;
    mdc = 1'b0;
    repeat (5) @(posedge ref_clk);
    s = mdio;
    #1 mdc = 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] rg, input logic [15:0] wd);
    logic [63:0] f;
    logic        s;
    f = {32'hFFFFFFFF, 2'b01, op, pa, rg, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      bit_cyc(f[i], !(op == 2'h2 && i < 18), s);
      if (i < 16) rd_data[i] = s;
    end
    sta_oe = 1'b0;
    if (op == 2'h2) begin
      rd_done = 1'b1;
      @(posedge ref_clk) #1 rd_done = 1'b0;
    end
  endtask
endmodule

/* File: pbcr_basic_control_tb.sv */
`timescale 1ns/1ns
module pbcr_basic_control_tb;
  logic        ref_clk, rst_n, mdc, sta_out, sta_oe, rd_done, mdio_out, mdio_oe, mdio_w;
  logic        autoneg_ability_pin, float_default_strap, power_down_pin, isolate_pin, tx_en, col_in;
  logic        pcs_bypass, an_speed_100, an_full_duplex, soft_reset_pulse, autoneg_restart_pulse;
  logic        autoneg_active, op_speed_100, op_full_duplex, low_power, mii_float;
  logic        medium_tx_enable, medium_rx_accept, loop_full_path, col_out;
  logic [2:0]  technology_straps;
  logic [15:0] rd_data, model;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  int          n_mismatch, check_count, cyc, n_restart, n_soft;
  // pull-up when nobody drives the management line
  assign mdio_w = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);
  pbcr_basic_control DUT (.ref_clk, .rst_n, .mdc, .mdio_in(mdio_w), .mdio_out, .mdio_oe, .phy_addr(5'h05),
    .technology_straps, .autoneg_ability_pin, .float_default_strap, .power_down_pin, .isolate_pin, .tx_en,
    .col_in, .pcs_bypass, .an_speed_100, .an_full_duplex, .soft_reset_pulse, .autoneg_restart_pulse,
    .autoneg_active, .op_speed_100, .op_full_duplex, .low_power, .mii_float, .medium_tx_enable,
    .medium_rx_accept, .loop_full_path, .col_out);
  pbcr_mgmt_station u_sta (.ref_clk, .mdio(mdio_w), .mdc, .sta_out, .sta_oe, .rd_done, .rd_data);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (autoneg_restart_pulse === 1'b1) n_restart++;
    if (soft_reset_pulse === 1'b1) n_soft++;
    if (cyc == 40000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  initial forever begin
    @(posedge rd_done);
    check("read", exp_q.pop_front(), rd_data);
  end
  function automatic logic [15:0] dflt(input logic [2:0] t, input logic ab, input logic iso);
    dflt = {2'b00, t[2] | t[1], ab, 1'b0, iso, 1'b0, t[2] | t[0], 8'h00};
  endfunction
  // strap-limited update of the expected register
  function automatic logic [15:0] apply(input logic [15:0] o, input logic [15:0] w, input logic [2:0] t);
    apply = {1'b0, w[14], o[13:12], w[11:10], 1'b0, o[8], w[7], 7'h00};
    if (w[13] ? (t[2] | t[1]) : (t[2] | !t[1])) apply[13] = w[13];
    if (!w[8] || t[2] || (t[0] && (t[1] == apply[13]))) apply[8] = w[8];
    if (!w[12] || autoneg_ability_pin) apply[12] = w[12];
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [4:0] pa, input logic [15:0] w);
    u_sta.frame(2'h1, pa, 5'h00, w);
    model = w[15] ? dflt(technology_straps, autoneg_ability_pin, float_default_strap) : apply(model, w, technology_straps);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] pa, input logic [4:0] rg, input logic [15:0] e);
    exp_q.push_back(e);
    u_sta.frame(2'h2, pa, rg, 16'h0000);
  endtask
  task automatic pins;
    logic an, lp;
    an = model[12] & autoneg_ability_pin;
    lp = model[11] | power_down_pin;
    check("pins", {8'h00, an, an ? an_speed_100 : model[13], an ? an_full_duplex : model[8], lp,
      model[10] | isolate_pin, model[14], !model[14] & !lp, !model[14]}, {8'h00, autoneg_active, op_speed_100,
      op_full_duplex, low_power, mii_float, loop_full_path, medium_tx_enable, medium_rx_accept});
  endtask
  task automatic do_reset(input logic [2:0] t, input logic ab, input logic iso);
    @(posedge ref_clk) #1 rst_n = 1'b0;
    technology_straps = t;
    autoneg_ability_pin = ab;
    float_default_strap = iso;
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    model = dflt(t, ab, iso);
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    {rst_n, power_down_pin, isolate_pin, tx_en, col_in, pcs_bypass, an_full_duplex} = 7'h00;
    an_speed_100 = 1'b1;
    seed = 32'h24EC;
    do_reset(3'h2, 1'b1, 1'b1);
    rd(5'h05, 5'h00, model);
    pins;
    wr(5'h05, 16'h0100);
    rd(5'h05, 5'h00, model);
    pins;
    $display("strap limits done");
    do_reset(3'h4, 1'b0, 1'b0);
    wr(5'h00, 16'h1200);
    check("restart", 16'h0001, n_restart[15:0]);
    rd(5'h05, 5'h00, model);
    autoneg_ability_pin = 1'b1;
    an_full_duplex = 1'b1;
    rd(5'h05, 5'h00, model);
    wr(5'h05, 16'h1000);
    pins;
    for (int k = 0; k < 6; k++) begin
      seed = lfsr_next(seed);
      {power_down_pin, isolate_pin} = seed[17:16];
      wr(5'h05, seed[15:0] & 16'h7FFF);
      rd(5'h00, 5'h00, model);
      pins;
    end
    $display("field writes done");
    {power_down_pin, isolate_pin} = 2'b00;
    wr(5'h05, 16'hC080);
    check("soft", 16'h0001, n_soft[15:0]);
    rd(5'h05, 5'h00, model);
    rd(5'h06, 5'h00, 16'hFFFF);
    rd(5'h05, 5'h01, 16'h0000);
    $display("soft reset and addressing done");
    wr(5'h05, 16'h0080);
    tx_en = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    check("col", 16'h0001, {15'h0000, col_out});
    pcs_bypass = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    check("col", 16'h0000, {15'h0000, col_out});
    {pcs_bypass, isolate_pin} = 2'b01;
    repeat (5) @(posedge ref_clk);
    #1;
    check("col", 16'h0000, {15'h0000, col_out});
    $display("collision test done");
    report_and_stop;
  end
endmodule
bind pbcr_basic_control pbcr_props u_props (.ref_clk, .rst_n, .autoneg_ability_pin, .power_down_pin, .isolate_pin,
  .tx_en, .col_in, .an_speed_100, .an_full_duplex, .soft_reset_pulse, .autoneg_restart_pulse, .autoneg_active,
  .op_speed_100, .op_full_duplex, .low_power, .mii_float, .medium_tx_enable, .medium_rx_accept, .loop_full_path,
  .col_out);
